// [verif/adrm_result_monitor_test.sv]
// Self-checking testbench of the converter result monitor.
`timescale 1ns/1ps
`default_nettype none
module adrm_result_monitor_test;
    import adrm_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic                 clk;
    logic                 arst_n;
    logic [ADDR_W-1:0]    addr;
    logic [DATA_W-1:0]    wrData;
    logic                 wrStb;
    logic                 rdStb;
    logic [DATA_W-1:0]    rdData;
    adrm_result_t         result;
    logic [NUM_MON-1:0]   monitor_match_irq;
    logic                 irq;
    int                   failures;
    int                   samples_checked;

    adrm_result_monitor i_dut (
        .clk               (clk),
        .arst_n            (arst_n),
        .addr              (addr),
        .wrData            (wrData),
        .wrStb             (wrStb),
        .rdStb             (rdStb),
        .rdData            (rdData),
        .result            (result),
        .monitor_match_irq (monitor_match_irq),
        .irq               (irq)
    );

    initial clk = 1'b0;
    always #4 clk = ~clk;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr   <= a;
        wrData <= d;
        wrStb  <= 1'b1;
        @(posedge clk);
        wrStb  <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr  <= a;
        rdStb <= 1'b1;
        @(posedge clk);
        rdStb <= 1'b0;
        #1;
        chk("read data", rdData, exp);
    endtask

    task automatic push(input logic [3:0] idx, input logic [11:0] val, input logic [1:0] expHit);
        @(posedge clk);
        result <= '{valid: 1'b1, index: idx, value: val};
        @(posedge clk);
        result.valid <= 1'b0;
        #1;
        chk("match pulse", {30'h0, monitor_match_irq}, {30'h0, expHit});
        @(posedge clk);
        #1;
        chk("match pulse end", {30'h0, monitor_match_irq}, 32'h0000_0000);
    endtask

    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_reset;
        for (int i = 0; i < 8; i++) begin
            rd(8'(i * 4), 32'h0000_0000);
        end
        chk("irq", {31'h0, irq}, 32'h0000_0000);
        $display("Test reset values done");
    endtask

    task automatic test_regs;
        wr(OFS_CTRL0, 32'hffff_ffff);
        wr(OFS_CTRL1, 32'hffff_ffff);
        wr(OFS_THR0, 32'hffff_ffff);
        wr(OFS_THR1, 32'h0000_a5a5);
        wr(OFS_RES0, 32'hffff_ffff);
        wr(8'h40, 32'hffff_ffff);
        rd(OFS_CTRL0, 32'h0000_0f9f);
        rd(OFS_CTRL1, 32'h0000_0f9f);
        rd(OFS_THR0, 32'h0000_fff0);
        rd(OFS_THR1, 32'h0000_a5a0);
        rd(OFS_RES0, 32'h0000_0000);
        rd(8'h40, 32'h0000_0000);
        @(posedge clk);
        addr   <= OFS_THR0;
        wrData <= 32'h0000_1230;
        wrStb  <= 1'b1;
        @(posedge clk);
        wrStb  <= 1'b0;
        rdStb  <= 1'b1;
        @(posedge clk);
        rdStb  <= 1'b0;
        #1;
        chk("write then read", rdData, 32'h0000_1230);
        wr(OFS_CTRL0, 32'h0000_0000);
        wr(OFS_CTRL1, 32'h0000_0000);
        $display("Test register access done");
    endtask

    task automatic test_flags;
        push(4'h0, 12'habc, 2'b00);
        rd(OFS_RES0, 32'h0000_abc1);
        rd(OFS_RES0, 32'h0000_abc0);
        push(4'h0, 12'h123, 2'b00);
        push(4'h0, 12'h456, 2'b00);
        rd(OFS_RES0, 32'h0000_4563);
        push(4'h1, 12'h321, 2'b00);
        push(4'h2, 12'h777, 2'b00);
        rd(OFS_RES1, 32'h0000_3211);
        rd(OFS_RES0, 32'h0000_4560);
        $display("Test result flags done");
    endtask

    task automatic test_compare;
        wr(OFS_THR0, 32'h0000_8000);
        wr(OFS_CTRL0, 32'h0000_0080);
        push(4'h0, 12'h800, 2'b01);
        push(4'h0, 12'h7ff, 2'b00);
        push(4'h0, 12'hfff, 2'b01);
        wr(OFS_CTRL0, 32'h0000_0090);
        push(4'h0, 12'h800, 2'b01);
        push(4'h0, 12'h801, 2'b00);
        push(4'h0, 12'h000, 2'b01);
        wr(OFS_THR1, 32'h0000_1000);
        wr(OFS_CTRL1, 32'h0000_0081);
        push(4'h1, 12'h100, 2'b10);
        push(4'h0, 12'h100, 2'b01);
        push(4'h1, 12'h0ff, 2'b00);
        $display("Test compare conditions done");
    endtask

    task automatic test_count;
        wr(OFS_CTRL1, 32'h0000_0000);
        wr(OFS_CTRL0, 32'h0000_0082);
        push(4'h2, 12'h900, 2'b00);
        wr(OFS_CTRL0, 32'h0000_0081);
        push(4'h1, 12'h900, 2'b01);
        wr(OFS_CTRL0, 32'h0000_0280);
        push(4'h0, 12'h900, 2'b00);
        push(4'h0, 12'h900, 2'b00);
        push(4'h0, 12'h900, 2'b01);
        push(4'h0, 12'h900, 2'b00);
        push(4'h0, 12'h100, 2'b00);
        push(4'h0, 12'h900, 2'b00);
        push(4'h0, 12'h900, 2'b00);
        push(4'h0, 12'h900, 2'b01);
        wr(OFS_CTRL0, 32'h0000_0f80);
        for (int i = 0; i < 16; i++) begin
            push(4'h0, 12'h900, (i == 15) ? 2'b01 : 2'b00);
        end
        wr(OFS_CTRL0, 32'h0000_0180);
        push(4'h0, 12'h900, 2'b00);
        wr(OFS_CTRL0, 32'h0000_0000);
        push(4'h0, 12'h900, 2'b00);
        wr(OFS_CTRL0, 32'h0000_0180);
        push(4'h0, 12'h900, 2'b00);
        push(4'h0, 12'h900, 2'b01);
        wr(OFS_CTRL0, 32'h0000_0000);
        $display("Test match count done");
    endtask

    task automatic test_irq;
        rd(OFS_STATUS, 32'h0000_0003);
        rd(OFS_STATUS, 32'h0000_0000);
        wr(OFS_MASK, 32'h0000_0001);
        wr(OFS_CTRL0, 32'h0000_0080);
        push(4'h0, 12'h900, 2'b01);
        @(posedge clk);
        #1;
        chk("irq", {31'h0, irq}, 32'h0000_0001);
        rd(OFS_STATUS, 32'h0000_0001);
        chk("irq", {31'h0, irq}, 32'h0000_0000);
        wr(OFS_MASK, 32'h0000_0002);
        push(4'h0, 12'h900, 2'b01);
        @(posedge clk);
        #1;
        chk("irq", {31'h0, irq}, 32'h0000_0000);
        rd(OFS_MASK, 32'h0000_0002);
        rd(OFS_STATUS, 32'h0000_0001);
        $display("Test interrupt done");
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        failures        = 0;
        samples_checked = 0;
        arst_n = 1'b0;
        addr   = 8'h00;
        wrData = 32'h0000_0000;
        wrStb  = 1'b0;
        rdStb  = 1'b0;
        result = '0;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        test_reset();
        test_regs();
        test_flags();
        test_compare();
        test_count();
        test_irq();
        finish_test();
    end

    initial begin
        #100000;
        failures++;
        $display("Watchdog expired");
        finish_test();
    end
endmodule
`default_nettype wire

// [verilog/adrm_monitor.sv]
// One threshold monitor with a consecutive-match counter.
`timescale 1ns/1ps
`default_nettype none
module adrm_monitor (
    input  wire logic                            clk,
    input  wire logic                            arst_n,
    input  wire adrm_pkg::adrm_ctrl_t            cfg,
    input  wire logic [adrm_pkg::VAL_W-1:0]      threshold,
    input  wire logic                            sampleValid,
    input  wire logic [adrm_pkg::VAL_W-1:0]      sampleValue,
    output var  logic                            matchPulse
);
    import adrm_pkg::*;

    logic [3:0] runReg;
    logic [3:0] runNext;
    logic       hit;
    logic       doCompare;
    logic       decide;

    // ------------------------------------------------------------------
    // Comparison
    // ------------------------------------------------------------------
    assign hit       = cfg.dir ? (sampleValue <= threshold) : (sampleValue >= threshold);
    assign doCompare = cfg.enable && sampleValid;
    assign decide    = doCompare && hit && (runReg >= cfg.count);

    assign runNext = !cfg.enable ? 4'h0 :
                     !doCompare  ? runReg :
                     (!hit || decide) ? 4'h0 : runReg + 4'h1;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            runReg     <= 4'h0;
            matchPulse <= 1'b0;
        end else begin
            runReg     <= runNext;
            matchPulse <= decide;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_hit;
        cfg.enable && sampleValid && hit;
    endsequence

    a_mon_disabled: assert property (!cfg.enable |=> !matchPulse)
        else $error("monitor fired while disabled");
    a_mon_single: assert property ((s_hit and (cfg.count == 4'h0)) |=> matchPulse)
        else $error("count zero did not decide on first match");
    a_mon_dir: assert property (doCompare && !hit |=> !matchPulse && runReg == 4'h0)
        else $error("miss did not restart the run");
    a_mon_early: assert property (matchPulse |-> $past(runReg) >= $past(cfg.count))
        else $error("match declared before the set count");
endmodule
`default_nettype wire

// [verilog/adrm_pkg.sv]
// Package of constants and carrier types for the converter result monitor.
package adrm_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 32;
    localparam int VAL_W     = 12;
    localparam int NUM_MON   = 2;
    localparam int NUM_RES   = 2;
    localparam int IDX_W     = 4;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CTRL0  = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CTRL1  = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_THR0   = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_THR1   = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_RES0   = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_RES1   = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_MASK   = 8'h1c;
    localparam logic [ADDR_W-1:0] OFS_STEP   = 8'h04;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int POS_COUNT   = 8;
    localparam int POS_ENABLE  = 7;
    localparam int POS_DIR     = 4;
    localparam int POS_SELECT  = 0;
    localparam int POS_VALUE   = 4;
    localparam int POS_OVERRUN = 1;
    localparam int POS_STORED  = 0;
    localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [3:0]       count;
        logic             enable;
        logic             dir;
        logic [IDX_W-1:0] sel;
    } adrm_ctrl_t;

    typedef struct packed {
        logic             valid;
        logic [IDX_W-1:0] index;
        logic [VAL_W-1:0] value;
    } adrm_result_t;

endpackage

// [verilog/adrm_result_monitor.sv]
// Result registers, threshold monitors and register port of the converter unit.
`timescale 1ns/1ps
`default_nettype none
module adrm_result_monitor (
    input  wire logic                             clk,
    input  wire logic                             arst_n,
    input  wire logic [adrm_pkg::ADDR_W-1:0]      addr,
    input  wire logic [adrm_pkg::DATA_W-1:0]      wrData,
    input  wire logic                             wrStb,
    input  wire logic                             rdStb,
    output var  logic [adrm_pkg::DATA_W-1:0]      rdData,
    input  wire adrm_pkg::adrm_result_t           result,
    output wire logic [adrm_pkg::NUM_MON-1:0]     monitor_match_irq,
    output wire logic                             irq
);
    import adrm_pkg::*;

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    if (NUM_MON != 2 || NUM_RES != 2) begin : g_size_check
        $error("read port serves exactly two monitors and two result registers");
    end

    // ------------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------------
    function automatic logic hits(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        hits = (a == ofs);
    endfunction

    function automatic logic [DATA_W-1:0] ctrlWord(input adrm_ctrl_t c);
        ctrlWord = RST_WORD;
        ctrlWord[POS_COUNT +: 4]      = c.count;
        ctrlWord[POS_ENABLE]          = c.enable;
        ctrlWord[POS_DIR]             = c.dir;
        ctrlWord[POS_SELECT +: IDX_W] = c.sel;
    endfunction

    function automatic logic [DATA_W-1:0] valWord(input logic [VAL_W-1:0] v);
        valWord = RST_WORD;
        valWord[POS_VALUE +: VAL_W] = v;
    endfunction

    adrm_ctrl_t                  ctrlReg   [NUM_MON];
    logic [VAL_W-1:0]            thrReg    [NUM_MON];
    logic [VAL_W-1:0]            valueReg  [NUM_RES];
    logic [NUM_RES-1:0]          storedReg;
    logic [NUM_RES-1:0]          overrunReg;
    logic [NUM_RES-1:0]          storeHit;
    logic [NUM_RES-1:0]          readClr;
    logic [NUM_MON-1:0]          ctrlWr;
    logic [NUM_MON-1:0]          thrWr;
    logic [NUM_MON-1:0]          sampleValid;
    logic [NUM_MON-1:0]          statusReg;
    logic [NUM_MON-1:0]          statusNext;
    logic [NUM_MON-1:0]          maskReg;
    logic                        statusRd;
    logic                        maskWr;
    logic [DATA_W-1:0]           rdMux;
    logic [DATA_W-1:0]           rdNext;

    assign statusRd = rdStb && hits(addr, OFS_STATUS);
    assign maskWr   = wrStb && hits(addr, OFS_MASK);

    // ------------------------------------------------------------------
    // Conversion result registers
    // ------------------------------------------------------------------
    genvar r;
    generate
        for (r = 0; r < NUM_RES; r++) begin : g_res
            assign storeHit[r] = result.valid && (result.index == IDX_W'(r));
            assign readClr[r]  = rdStb && hits(addr, OFS_RES0 + ADDR_W'(r) * OFS_STEP);

            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    valueReg[r]   <= '0;
                    storedReg[r]  <= 1'b0;
                    overrunReg[r] <= 1'b0;
                end else begin
                    if (storeHit[r]) begin
                        valueReg[r] <= result.value;
                    end
                    storedReg[r]  <= storeHit[r] | (storedReg[r] & ~readClr[r]);
                    overrunReg[r] <= (storeHit[r] & storedReg[r] & ~readClr[r])
                                   | (overrunReg[r] & ~readClr[r]);
                end
            end

            a_store_flag: assert property (@(posedge clk) disable iff (!arst_n)
                storeHit[r] |=> storedReg[r] && valueReg[r] == $past(result.value))
                else $error("stored flag or value not updated");
            a_read_clears: assert property (@(posedge clk) disable iff (!arst_n)
                readClr[r] && !storeHit[r] |=> !storedReg[r] && !overrunReg[r])
                else $error("read did not clear result flags");
            a_overrun_set: assert property (@(posedge clk) disable iff (!arst_n)
                storeHit[r] && storedReg[r] && !readClr[r] |=> overrunReg[r])
                else $error("overrun not flagged");
        end
    endgenerate

    // ------------------------------------------------------------------
    // Monitors and their configuration
    // ------------------------------------------------------------------
    genvar m;
    generate
        for (m = 0; m < NUM_MON; m++) begin : g_mon
            assign ctrlWr[m] = wrStb && hits(addr, OFS_CTRL0 + ADDR_W'(m) * OFS_STEP);
            assign thrWr[m]  = wrStb && hits(addr, OFS_THR0 + ADDR_W'(m) * OFS_STEP);
            assign sampleValid[m] = result.valid && (result.index == ctrlReg[m].sel)
                                  && (ctrlReg[m].sel < IDX_W'(NUM_RES));

            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    ctrlReg[m] <= '0;
                    thrReg[m]  <= '0;
                end else begin
                    if (ctrlWr[m]) begin
                        ctrlReg[m] <= '{count:  wrData[POS_COUNT +: 4],
                                        enable: wrData[POS_ENABLE],
                                        dir:    wrData[POS_DIR],
                                        sel:    wrData[POS_SELECT +: IDX_W]};
                    end
                    if (thrWr[m]) begin
                        thrReg[m] <= wrData[POS_VALUE +: VAL_W];
                    end
                end
            end

            adrm_monitor u_mon (
                .clk         (clk),
                .arst_n      (arst_n),
                .cfg         (ctrlReg[m]),
                .threshold   (thrReg[m]),
                .sampleValid (sampleValid[m]),
                .sampleValue (result.value),
                .matchPulse  (monitor_match_irq[m])
            );

            a_sel_ignored: assert property (@(posedge clk) disable iff (!arst_n)
                ctrlReg[m].sel >= IDX_W'(NUM_RES) |=> !monitor_match_irq[m])
                else $error("monitor fired on a missing result register");
        end
    endgenerate

    // ------------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------------
    assign statusNext = monitor_match_irq | (statusReg & ~{NUM_MON{statusRd}});
    assign irq        = |(statusReg & maskReg);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            statusReg <= '0;
            maskReg   <= '0;
        end else begin
            statusReg <= statusNext;
            if (maskWr) begin
                maskReg <= wrData[NUM_MON-1:0];
            end
        end
    end

    a_status_sticky: assert property (@(posedge clk) disable iff (!arst_n)
        monitor_match_irq[0] |=> statusReg[0] ##0 (statusReg[0] || $past(statusRd)))
        else $error("match event lost from status");

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    assign rdMux = hits(addr, OFS_CTRL0)  ? ctrlWord(ctrlReg[0]) :
                   hits(addr, OFS_CTRL1)  ? ctrlWord(ctrlReg[1]) :
                   hits(addr, OFS_THR0)   ? valWord(thrReg[0]) :
                   hits(addr, OFS_THR1)   ? valWord(thrReg[1]) :
                   hits(addr, OFS_RES0)   ? (valWord(valueReg[0])
                                            | {30'h0, overrunReg[0], storedReg[0]}) :
                   hits(addr, OFS_RES1)   ? (valWord(valueReg[1])
                                            | {30'h0, overrunReg[1], storedReg[1]}) :
                   hits(addr, OFS_STATUS) ? {30'h0, statusReg} :
                   hits(addr, OFS_MASK)   ? {30'h0, maskReg} : RST_WORD;
    assign rdNext = rdStb ? rdMux : RST_WORD;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdData <= RST_WORD;
        end else begin
            rdData <= rdNext;
        end
    end

    a_unused_zero: assert property (@(posedge clk) disable iff (!arst_n)
        rdStb && (hits(addr, OFS_THR0) || hits(addr, OFS_RES0)) |=> rdData[3:2] == 2'b00
        && rdData[31:16] == 16'h0000)
        else $error("unused bits read non-zero");
    a_thr_readback: assert property (@(posedge clk) disable iff (!arst_n)
        wrStb && hits(addr, OFS_THR0) ##1 rdStb && hits(addr, OFS_THR0)
        |=> rdData[15:4] == $past(wrData[15:4], 2))
        else $error("threshold did not read back");
    a_irq_level: assert property (@(posedge clk) disable iff (!arst_n)
        irq == |(statusReg & maskReg))
        else $error("interrupt output disagrees with status and mask");
endmodule
`default_nettype wire
